// ---- verilog/dcc_regs.svh ----
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
// register indices reached through the pointer
`define DCC_IDX_CMD 5'h00
`define DCC_IDX_ICTL 5'h01
`define DCC_IDX_IVEC 5'h02
// reset values
`define DCC_PTR_RST 5'h00
`define DCC_BYTE_RST 8'h00
`define DCC_CH_RST 4'h0
// command field and codes
`define DCC_CMD_HI 7
`define DCC_CMD_LO 5
`define DCC_PTR_HI 4
`define DCC_CMD_NULL 3'h0
`define DCC_CMD_RSVD 3'h1
`define DCC_CMD_RST_IUS 3'h2
`define DCC_CMD_RESET 3'h3
`define DCC_CMD_EN_TXB 3'h4
`define DCC_CMD_EN_RXB 3'h5
`define DCC_CMD_EN_TXA 3'h6
`define DCC_CMD_EN_RXA 3'h7
// interrupt control fields
`define DCC_ICTL_MIE 7
`define DCC_ICTL_DLC 6
`define DCC_ICTL_NOVEC 5
`define DCC_ICTL_VIS 4
`define DCC_ICTL_IE_HI 3
// channel bit positions
`define DCC_CH_RXA 3
`define DCC_CH_TXA 2
`define DCC_CH_RXB 1
`define DCC_CH_TXB 0
// vector status field and codes
`define DCC_VEC_ST_HI 3
`define DCC_VEC_ST_LO 1
`define DCC_BYTE_HI 7
`define DCC_VST_NONE 3'h0
`define DCC_VST_RXA 3'h4
`define DCC_VST_RXB 3'h5
`define DCC_VST_TXA 3'h6
`define DCC_VST_TXB 3'h7
`endif

// ---- verilog/dcc_pkg.sv ----
package dcc_pkg;
   typedef logic [3:0] dcc_chan_t;
   typedef logic [7:0] dcc_byte_t;
   typedef logic [4:0] dcc_ptr_t;
endpackage : dcc_pkg

// ---- verilog/dcc_dma_cmd_irq.sv ----
`timescale 1ns/100ps
`include "dcc_regs.svh"
module dcc_dma_cmd_irq
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   // register access
   input wire logic bus_sel,
   input wire logic bus_wr,
   input wire dcc_byte_t bus_wdata,
   output dcc_byte_t bus_rdata,
   // channel events
   input wire dcc_chan_t tc_evt,
   input wire dcc_chan_t abort_evt,
   input wire dcc_chan_t irq_evt,
   input wire dcc_chan_t irq_clr,
   // channel control
   output dcc_chan_t chan_enable,
   output logic cell_reset,
   // interrupt chain
   input wire logic chain_enable_in,
   input wire logic intack_vec,
   output logic irq_request,
   output logic chain_enable_out,
   output dcc_byte_t vec_data,
   output logic vec_oe,
   output dcc_chan_t irq_pending_flag,
   output dcc_chan_t irq_in_service
);

   // state
   dcc_ptr_t ptr_reg;
   dcc_ptr_t ptr_next;
   dcc_byte_t status_reg;
   dcc_byte_t status_next;
   dcc_byte_t ictl_reg;
   dcc_byte_t ictl_next;
   dcc_byte_t ivec_reg;
   dcc_byte_t ivec_next;
   dcc_byte_t rdata_reg;
   dcc_byte_t rdata_next;
   dcc_chan_t en_reg;
   dcc_chan_t en_next;
   dcc_chan_t ip_reg;
   dcc_chan_t ip_next;
   dcc_chan_t ius_reg;
   dcc_chan_t ius_next;
   dcc_byte_t vec_reg;
   dcc_byte_t vec_next;
   logic vec_oe_reg;
   logic vec_oe_next;
   logic crst_reg;
   logic crst_next;
   logic [2:0] iei_sync;
   logic iei_reg;
   logic iei_next;

   // access decode
   wire logic at_cmd;
   wire logic at_ictl;
   wire logic at_ivec;
   wire logic iei_agree;
   wire dcc_byte_t stat_evt;
   wire logic wr_acc;
   wire logic rd_acc;
   wire logic wr_cmd;
   wire logic rd_stat;
   wire logic wr_ictl;
   wire logic wr_ivec;
   wire logic [2:0] cmd;
   wire logic do_reset;
   wire logic do_rst_ius;
   wire logic master_irq_enable;
   wire logic lower_chain_disable;
   wire logic no_vector;
   wire logic vector_with_status;
   wire dcc_chan_t ie;
   wire dcc_chan_t ip_en;
   wire dcc_chan_t req;
   wire dcc_chan_t win;
   wire dcc_chan_t ius_hi;
   wire dcc_chan_t en_set;
   wire logic [2:0] vst;
   wire dcc_byte_t vec_out;
   wire logic ack_take;
   wire dcc_byte_t rd_mux;

   assign at_cmd = (ptr_reg == `DCC_IDX_CMD);
   assign at_ictl = (ptr_reg == `DCC_IDX_ICTL);
   assign at_ivec = (ptr_reg == `DCC_IDX_IVEC);
   assign wr_acc = bus_sel & bus_wr;
   assign rd_acc = bus_sel & ~bus_wr;
   assign wr_cmd = wr_acc & at_cmd;
   assign rd_stat = rd_acc & at_cmd;
   assign wr_ictl = wr_acc & at_ictl;
   assign wr_ivec = wr_acc & at_ivec;
   assign cmd = bus_wdata[`DCC_CMD_HI:`DCC_CMD_LO];

   // command decode; null and reserved codes fall through untouched
   assign do_reset = wr_cmd & (cmd == `DCC_CMD_RESET);
   assign do_rst_ius = wr_cmd & (cmd == `DCC_CMD_RST_IUS);
   assign en_set[`DCC_CH_TXB] = wr_cmd & (cmd == `DCC_CMD_EN_TXB);
   assign en_set[`DCC_CH_RXB] = wr_cmd & (cmd == `DCC_CMD_EN_RXB);
   assign en_set[`DCC_CH_TXA] = wr_cmd & (cmd == `DCC_CMD_EN_TXA);
   assign en_set[`DCC_CH_RXA] = wr_cmd & (cmd == `DCC_CMD_EN_RXA);

   // interrupt control fields
   assign master_irq_enable = ictl_reg[`DCC_ICTL_MIE];
   assign lower_chain_disable = ictl_reg[`DCC_ICTL_DLC];
   assign no_vector = ictl_reg[`DCC_ICTL_NOVEC];
   assign vector_with_status = ictl_reg[`DCC_ICTL_VIS];
   assign ie = ictl_reg[`DCC_ICTL_IE_HI:0];

   // requests per channel
   assign ip_en = ip_reg & ie;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_req
         assign req[g] = ip_en[g] & master_irq_enable & iei_reg & ~ius_reg[g];
      end
   endgenerate
   assign irq_request = |req & ~|ius_reg;

   // fixed priority: rx A, tx A, rx B, tx B
   assign win[3] = req[3];
   assign win[2] = req[2] & ~req[3];
   assign win[1] = req[1] & ~|req[3:2];
   assign win[0] = req[0] & ~|req[3:1];
   assign ius_hi[3] = ius_reg[3];
   assign ius_hi[2] = ius_reg[2] & ~ius_reg[3];
   assign ius_hi[1] = ius_reg[1] & ~|ius_reg[3:2];
   assign ius_hi[0] = ius_reg[0] & ~|ius_reg[3:1];

   // vector status of highest pending and enabled source
   assign vst = ip_en[`DCC_CH_RXA] ? `DCC_VST_RXA :
                ip_en[`DCC_CH_TXA] ? `DCC_VST_TXA :
                ip_en[`DCC_CH_RXB] ? `DCC_VST_RXB :
                ip_en[`DCC_CH_TXB] ? `DCC_VST_TXB :
                `DCC_VST_NONE;
   assign vec_out = vector_with_status ?
      {ivec_reg[`DCC_BYTE_HI:`DCC_VEC_ST_HI + 1], vst, ivec_reg[`DCC_VEC_ST_LO - 1:0]} :
      ivec_reg;

   // daisy chain
   assign chain_enable_out = iei_reg & ~lower_chain_disable
                           & ~|ius_reg & ~irq_request;
   assign ack_take = intack_vec & irq_request;
   assign iei_agree = (iei_sync[1] == iei_sync[2]);

   // read data
   assign rd_mux = at_cmd ? status_reg :
                   at_ictl ? ictl_reg :
                   at_ivec ? ivec_reg :
                   `DCC_BYTE_RST;
   assign stat_evt = {tc_evt, abort_evt};

   always_comb begin
      ptr_next = ptr_reg;
      if (wr_cmd) begin
         ptr_next = bus_wdata[`DCC_PTR_HI:0];
      end else if (bus_sel) begin
         ptr_next = `DCC_PTR_RST;
      end
   end

   always_comb begin
      status_next = status_reg;
      if (rd_stat) begin
         status_next = `DCC_BYTE_RST;
      end
      status_next = status_next | stat_evt;
      if (do_reset) begin
         status_next = `DCC_BYTE_RST;
      end
   end

   always_comb begin
      ictl_next = ictl_reg;
      ivec_next = ivec_reg;
      if (wr_ictl) begin
         ictl_next = bus_wdata;
      end
      if (wr_ivec) begin
         ivec_next = bus_wdata;
      end
   end

   always_comb begin
      en_next = en_reg | en_set;
      if (do_reset) begin
         en_next = `DCC_CH_RST;
      end
   end

   always_comb begin
      ip_next = (ip_reg & ~irq_clr) | irq_evt;
      ius_next = ius_reg;
      if (do_rst_ius) begin
         ius_next = ius_reg & ~ius_hi;
      end
      if (ack_take) begin
         ius_next = ius_next | win;
      end
      if (do_reset) begin
         ip_next = `DCC_CH_RST;
         ius_next = `DCC_CH_RST;
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (rd_acc) begin
         rdata_next = rd_mux;
      end
   end

   // vector capture on an accepted acknowledge
   always_comb begin
      vec_next = vec_reg;
      vec_oe_next = 1'b0;
      if (ack_take) begin
         vec_next = vec_out;
         vec_oe_next = ~no_vector;
      end
   end

   always_comb begin
      crst_next = do_reset;
   end

   // chain input counts once the last two stages agree
   always_comb begin
      iei_next = iei_reg;
      if (iei_agree) begin
         iei_next = iei_sync[2];
      end
   end

   // pin input synchroniser
   always_ff @(posedge clk) begin
      iei_sync <= {iei_sync[1:0], chain_enable_in};
   end

   always_ff @(posedge clk) begin
      if (sys_rst | soft_rst) begin
         ptr_reg <= `DCC_PTR_RST;
         status_reg <= `DCC_BYTE_RST;
         ictl_reg <= `DCC_BYTE_RST;
         ivec_reg <= `DCC_BYTE_RST;
         rdata_reg <= `DCC_BYTE_RST;
         en_reg <= `DCC_CH_RST;
         ip_reg <= `DCC_CH_RST;
         ius_reg <= `DCC_CH_RST;
         vec_reg <= `DCC_BYTE_RST;
         vec_oe_reg <= 1'b0;
         crst_reg <= 1'b0;
         iei_reg <= 1'b0;
      end else begin
         ptr_reg <= ptr_next;
         status_reg <= status_next;
         ictl_reg <= ictl_next;
         ivec_reg <= ivec_next;
         rdata_reg <= rdata_next;
         en_reg <= en_next;
         ip_reg <= ip_next;
         ius_reg <= ius_next;
         vec_reg <= vec_next;
         vec_oe_reg <= vec_oe_next;
         crst_reg <= crst_next;
         iei_reg <= iei_next;
      end
   end

   // outputs
   assign bus_rdata = rdata_reg;
   assign chan_enable = en_reg;
   assign cell_reset = crst_reg;
   assign vec_data = vec_reg;
   assign vec_oe = vec_oe_reg;
   assign irq_pending_flag = ip_reg;
   assign irq_in_service = ius_reg;

endmodule : dcc_dma_cmd_irq

// ---- tb/dcc_dma_cmd_irq_properties.sv ----
`timescale 1ns/100ps
module dcc_chk
   import dcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic soft_rst,
   // bus and chain
   input wire logic bus_sel,
   input wire logic bus_wr,
   input wire dcc_byte_t bus_wdata,
   input wire logic chain_enable_in,
   input wire logic intack_vec,
   // outputs watched
   input wire logic irq_request,
   input wire logic chain_enable_out,
   input wire logic vec_oe,
   input wire logic cell_reset,
   input wire dcc_chan_t chan_enable,
   input wire dcc_chan_t irq_pending_flag,
   input wire dcc_chan_t irq_in_service
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || soft_rst);
   sequence s_ack; intack_vec && irq_request; endsequence
   sequence s_chain_off; !chain_enable_in [*4]; endsequence
   property p_req_pend; irq_request |-> irq_pending_flag != 4'h0; endproperty
   a_req_pend: assert property (p_req_pend) else $error("request without pending");
   property p_ius_block; irq_in_service != 4'h0 |-> !irq_request; endproperty
   a_ius_block: assert property (p_ius_block) else $error("request while in service");
   property p_chain_off; s_chain_off |=> !irq_request && !chain_enable_out; endproperty
   a_chain_off: assert property (p_chain_off) else $error("active with chain low");
   property p_ack_ius; s_ack |=> irq_in_service != 4'h0; endproperty
   a_ack_ius: assert property (p_ack_ius) else $error("ack set no service bit");
   property p_ius_cause; (irq_in_service & ~$past(irq_in_service)) != 4'h0 |-> $past(intack_vec);
   endproperty
   a_ius_cause: assert property (p_ius_cause) else $error("service bit without ack");
   property p_oe_cause; vec_oe |-> $past(intack_vec && irq_request); endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("vector without ack");
   property p_cell_rst; cell_reset |-> chan_enable == 4'h0 && irq_in_service == 4'h0; endproperty
   a_cell_rst: assert property (p_cell_rst) else $error("cell reset left state");
   property p_rst_pulse;
      cell_reset |=> !cell_reset || $past(bus_sel && bus_wr && bus_wdata[7:5] == 3'h3);
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("cell reset too long");
   property p_en_cause;
      (chan_enable & ~$past(chan_enable)) != 4'h0 |-> $past(bus_sel && bus_wr && bus_wdata[7]);
   endproperty
   a_en_cause: assert property (p_en_cause) else $error("enable without command");
endmodule : dcc_chk
bind dcc_dma_cmd_irq dcc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
   .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
   .chain_enable_in(chain_enable_in), .intack_vec(intack_vec), .irq_request(irq_request),
   .chain_enable_out(chain_enable_out), .vec_oe(vec_oe), .cell_reset(cell_reset),
   .chan_enable(chan_enable), .irq_pending_flag(irq_pending_flag),
   .irq_in_service(irq_in_service));

// ---- tb/dcc_host.sv ----
`timescale 1ns/100ps
module dcc_host
   import dcc_pkg::*;
(
   // parallel bus
   input wire logic clk,
   output logic bus_sel,
   output logic bus_wr,
   output dcc_byte_t bus_wdata,
   input wire dcc_byte_t bus_rdata
);
   initial begin
      {bus_sel, bus_wr, bus_wdata} = 10'h000;
   end
   task automatic acc(input logic w, input dcc_byte_t d);
      @(posedge clk);
      {bus_sel, bus_wr, bus_wdata} <= {1'b1, w, d};
      @(posedge clk);
      bus_sel <= 1'b0;
      bus_wdata <= ~d;
      #1;
   endtask : acc
   // pointer load first unless the index is 0, then the single steered access
   task automatic wr(input dcc_ptr_t idx, input dcc_byte_t d);
      if (idx != 5'h00) acc(1'b1, {3'h0, idx});
      acc(1'b1, d);
   endtask : wr
   task automatic rd(input dcc_ptr_t idx, output dcc_byte_t q);
      if (idx != 5'h00) acc(1'b1, {3'h0, idx});
      acc(1'b0, 8'h00);
      q = bus_rdata;
   endtask : rd
endmodule : dcc_host

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "dcc_regs.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %h got %h", n, e, a); end end
module testbench
   import dcc_pkg::*;
;
   logic clk, sys_rst, soft_rst, bus_sel, bus_wr, cell_reset, chain_enable_in, intack_vec;
   logic irq_request, chain_enable_out, vec_oe;
   dcc_byte_t bus_wdata, bus_rdata, vec_data, q;
   dcc_chan_t tc_evt, abort_evt, irq_evt, irq_clr, chan_enable, irq_pending_flag, irq_in_service;
   logic [2:0] vst [4] = '{3'h7, 3'h5, 3'h6, 3'h4};
   int error_cnt = 0;
   int n_tests = 0;
   initial clk = 1'b0;
   always #25 clk = ~clk;
   dcc_host u_dcc_host (.clk(clk), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata));
   dcc_dma_cmd_irq u_dcc_dma_cmd_irq (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
      .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .tc_evt(tc_evt), .abort_evt(abort_evt), .irq_evt(irq_evt), .irq_clr(irq_clr),
      .chan_enable(chan_enable), .cell_reset(cell_reset), .chain_enable_in(chain_enable_in),
      .intack_vec(intack_vec), .irq_request(irq_request), .chain_enable_out(chain_enable_out),
      .vec_data(vec_data), .vec_oe(vec_oe), .irq_pending_flag(irq_pending_flag),
      .irq_in_service(irq_in_service));
   task automatic ev(input logic [15:0] v);
      @(posedge clk);
      {tc_evt, abort_evt, irq_evt, irq_clr} <= v;
      @(posedge clk);
      {tc_evt, abort_evt, irq_evt, irq_clr} <= 16'h0000;
      #1;
   endtask : ev
   task automatic ack();
      @(posedge clk);
      intack_vec <= 1'b1;
      @(posedge clk);
      intack_vec <= 1'b0;
      #1;
   endtask : ack
   task automatic close_out();
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (2000) @(posedge clk);
      error_cnt++;
      close_out();
   end
   initial begin
      {sys_rst, soft_rst, chain_enable_in, intack_vec} = 4'b1010;
      {tc_evt, abort_evt, irq_evt, irq_clr} = 16'h0000;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      u_dcc_host.rd(`DCC_IDX_ICTL, q);
      `CHK("ictl reset", 8'h00, q)
      u_dcc_host.rd(5'h1f, q);
      `CHK("unmapped", 8'h00, q)
      ev(16'ha500);
      u_dcc_host.rd(5'h00, q);
      `CHK("status", 8'ha5, q)
      u_dcc_host.rd(5'h00, q);
      `CHK("status cleared", 8'h00, q)
      for (int c = 4; c < 8; c++) begin
         u_dcc_host.wr(5'h00, {c[2:0], 5'h00});
         `CHK("enable", dcc_chan_t'((1 << (c - 3)) - 1), chan_enable)
      end
      u_dcc_host.wr(5'h00, 8'h20);
      u_dcc_host.wr(5'h00, 8'h00);
      `CHK("null cmds", 4'hf, chan_enable)
      u_dcc_host.wr(5'h00, 8'h60);
      `CHK("cell reset", 4'h0, chan_enable)
      `CHK("cell reset pulse", 1'b1, cell_reset)
      u_dcc_host.wr(`DCC_IDX_IVEC, 8'hf1);
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'h1f);
      ev(16'h00f0);
      `CHK("mie off", 1'b0, irq_request)
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'h9f);
      `CHK("request", 1'b1, irq_request)
      @(posedge clk) chain_enable_in <= 1'b0;
      repeat (6) @(posedge clk);
      #1 `CHK("chain low", 1'b0, irq_request)
      @(posedge clk) chain_enable_in <= 1'b1;
      repeat (5) @(posedge clk);
      for (int k = 3; k >= 0; k--) begin
         ack();
         `CHK("vector", {4'hf, vst[k], 1'b1}, vec_data)
         `CHK("vec oe", 1'b1, vec_oe)
         ev({12'h000, dcc_chan_t'(1 << k)});
         `CHK("pending", dcc_chan_t'((1 << k) - 1), irq_pending_flag)
         u_dcc_host.wr(5'h00, 8'h40);
         `CHK("ius clear", 4'h0, irq_in_service)
      end
      ev(16'h00f0);
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'hbf);
      ack();
      `CHK("no vector", 1'b0, vec_oe)
      `CHK("ius set", 4'h8, irq_in_service)
      @(posedge clk) chain_enable_in <= 1'b0;
      repeat (5) @(posedge clk);
      u_dcc_host.wr(5'h00, 8'h40);
      `CHK("ius clear chain low", 4'h0, irq_in_service)
      @(posedge clk) chain_enable_in <= 1'b1;
      repeat (5) @(posedge clk);
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'h8f);
      ack();
      `CHK("plain vector", 8'hf1, vec_data)
      u_dcc_host.wr(5'h00, 8'h40);
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'h92);
      ack();
      `CHK("masked vector", {4'hf, vst[1], 1'b1}, vec_data)
      `CHK("masked winner", 4'h2, irq_in_service)
      u_dcc_host.wr(5'h00, 8'h40);
      ev(16'h000f);
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'h40);
      `CHK("chain dis", 1'b0, chain_enable_out)
      u_dcc_host.wr(`DCC_IDX_ICTL, 8'h00);
      `CHK("chain on", 1'b1, chain_enable_out)
      u_dcc_host.wr(5'h00, 8'h80);
      ev(16'h5a30);
      `CHK("pending set", 4'h3, irq_pending_flag)
      @(posedge clk) soft_rst <= 1'b1;
      @(posedge clk) soft_rst <= 1'b0;
      #1 `CHK("soft enables", 4'h0, chan_enable)
      `CHK("soft pending", 4'h0, irq_pending_flag)
      u_dcc_host.rd(5'h00, q);
      `CHK("soft status", 8'h00, q)
      close_out();
   end
endmodule : testbench
